/* File: rtl/iam_params.svh */
/*
  Address map constants for the indirect access mapper.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef IAM_PARAMS_SVH
`define IAM_PARAMS_SVH

// banked data space
`define BANK_TOP        16'h0fff
`define BANK_OFF_W      7
`define PORT_SLOT0      7'h00
`define PORT_SLOT1      7'h01
`define ZERO_BYTE       8'h00

// linear view of general purpose ram
`define LIN_BASE        16'h2000
`define LIN_TOP         16'h29af
`define RAM_BLOCK_BYTES 12'd80
`define RAM_BANK_BASE   7'h20
`define RAM_BANKS_IMPL  5'd13

// program flash view
`define FLASH_SEL_BIT   15

// eeprom view
`define EE_HIGH         8'h70

`endif

/* File: rtl/iam_pkg.sv */
/*
  Types shared by the indirect access mapper files.
  Assumes nothing of its surroundings.
*/
package iam_pkg;

  typedef enum logic [2:0] {
    REG_NULL,
    REG_BANK,
    REG_LINEAR,
    REG_FLASH,
    REG_EEPROM
  } region_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_EXTRA,
    ST_LATCH
  } state_t;

endpackage

/* File: rtl/indirect_address_mapper.sv */
/*
  Indirect data port address mapper: routes core accesses to banked
  ram, linear ram view, flash low byte or eeprom.
  Assumes memories return read data the cycle after their strobe and
  hold it until their next strobe; one core access at a time.
*/
// Overview of operation
// [R1] port access reaches the location the pointer currently holds
// [R2] pointer at an indirect port slot reads zero, write suppressed
// [R3] pointer is high byte concatenated with low byte, 16 bits
// [R4] 0x000 to 0xfff map one-to-one onto absolute banked addresses
// [R5] 0x2000 to 0x29af map onto the 80-byte ram blocks of banks
// [R6] linear reads of unimplemented memory return 0x00
// [R7] linear window runs straight on into the next bank's block
// [R8] common memory is left out of the linear window
// [R9] pointer msb set selects a flash word with the low 15 bits
// [R10] flash reads deliver only the low eight bits
// [R11] writes into the flash view never modify flash
// [R12] any flash view access takes one extra cycle
// [R13] high byte 0x70 selects an eeprom byte by the low byte
// [R14] writes into the eeprom view leave eeprom unchanged
// [R15] eeprom view reads take one extra cycle
// [R16] unmapped pointers read zero and discard writes
`timescale 1ns/1ps
`default_nettype none
`include "iam_params.svh"

module indirect_address_mapper
  import iam_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic        ACC_REQ,
  input  wire logic        ACC_WRITE,
  input  wire logic [7:0]  PTR_HIGH,
  input  wire logic [7:0]  PTR_LOW,
  input  wire logic [7:0]  WR_DATA,
  output logic             ACC_BUSY,
  output logic             ACC_DONE,
  output logic      [7:0]  RD_DATA,
  output logic      [11:0] BANK_ADDR,
  output logic             BANK_RD,
  output logic             BANK_WR,
  output logic      [7:0]  BANK_WDATA,
  input  wire logic [7:0]  BANK_RDATA,
  output logic      [14:0] FLASH_ADDR,
  output logic             FLASH_RD,
  input  wire logic [13:0] FLASH_RDATA,
  output logic      [7:0]  EE_ADDR,
  output logic             EE_RD,
  input  wire logic [7:0]  EE_RDATA
);

  logic [15:0] ptr;
  logic [11:0] lin_addr;
  logic        lin_window;
  logic        lin_impl;
  logic        take;
  logic        slot_hit;
  logic        need_extra;
  region_t     decoded;

  state_t      state;
  state_t      next_state;
  region_t     region;
  region_t     next_region;
  logic        wr;
  logic        next_wr;
  logic        done;
  logic        next_done;
  logic [7:0]  rd_data;
  logic [7:0]  next_rd_data;
  logic [11:0] bank_addr;
  logic [11:0] next_bank_addr;
  logic [14:0] flash_addr;
  logic [14:0] next_flash_addr;
  logic [7:0]  ee_addr;
  logic [7:0]  next_ee_addr;
  logic [7:0]  wdata;
  logic [7:0]  next_wdata;

  assign ptr  = {PTR_HIGH, PTR_LOW}; // [R3]
  assign take = ACC_REQ && (state == ST_IDLE);

  linear_map u_linear_map (
    .ptr         (ptr),
    .abs_addr    (lin_addr),
    .in_window   (lin_window),
    .implemented (lin_impl)
  );

  // an indirect port slot repeats at the same offset in every bank
  assign slot_hit = (ptr[`BANK_OFF_W-1:0] == `PORT_SLOT0) ||
                    (ptr[`BANK_OFF_W-1:0] == `PORT_SLOT1);

  always_comb begin
    if (ptr[`FLASH_SEL_BIT]) begin
      decoded = REG_FLASH; // [R9]
    end else if (PTR_HIGH == `EE_HIGH) begin
      decoded = REG_EEPROM; // [R13]
    end else if (ptr <= `BANK_TOP) begin
      decoded = slot_hit ? REG_NULL : REG_BANK; // [R2] [R4]
    end else if (lin_window && lin_impl) begin
      decoded = REG_LINEAR; // [R5]
    end else begin
      decoded = REG_NULL; // [R6] [R16]
    end
  end

  // flash costs a cycle either way; eeprom only when read
  assign need_extra = (region == REG_FLASH) ||
                      ((region == REG_EEPROM) && !wr); // [R12] [R15]

  always_comb begin
    next_state      = state;
    next_region     = region;
    next_wr         = wr;
    next_done       = 1'b0;
    next_rd_data    = rd_data;
    next_bank_addr  = bank_addr;
    next_flash_addr = flash_addr;
    next_ee_addr    = ee_addr;
    next_wdata      = wdata;
    case (state)
      ST_IDLE: begin
        if (ACC_REQ) begin
          next_state      = ST_ISSUE;
          next_region     = decoded;
          next_wr         = ACC_WRITE;
          next_wdata      = WR_DATA;
          next_flash_addr = ptr[14:0]; // [R9]
          next_ee_addr    = PTR_LOW; // [R13]
          if (decoded == REG_LINEAR) begin
            next_bank_addr = lin_addr; // [R7]
          end else begin
            next_bank_addr = ptr[11:0]; // [R4]
          end
        end
      end
      ST_ISSUE: begin
        next_state = need_extra ? ST_EXTRA : ST_LATCH; // [R12] [R15]
      end
      ST_EXTRA: begin
        next_state = ST_LATCH;
      end
      ST_LATCH: begin
        next_state = ST_IDLE;
        next_done  = 1'b1;
        if (!wr) begin
          case (region)
            REG_BANK:   next_rd_data = BANK_RDATA; // [R1]
            REG_LINEAR: next_rd_data = BANK_RDATA; // [R1]
            REG_FLASH:  next_rd_data = FLASH_RDATA[7:0]; // [R10]
            REG_EEPROM: next_rd_data = EE_RDATA;
            default:    next_rd_data = `ZERO_BYTE; // [R2] [R6] [R16]
          endcase
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state      <= ST_IDLE;
      region     <= REG_NULL;
      wr         <= 1'b0;
      done       <= 1'b0;
      rd_data    <= 8'h00;
      bank_addr  <= 12'h000;
      flash_addr <= 15'h0000;
      ee_addr    <= 8'h00;
      wdata      <= 8'h00;
    end else begin
      state      <= next_state;
      region     <= next_region;
      wr         <= next_wr;
      done       <= next_done;
      rd_data    <= next_rd_data;
      bank_addr  <= next_bank_addr;
      flash_addr <= next_flash_addr;
      ee_addr    <= next_ee_addr;
      wdata      <= next_wdata;
    end
  end

  assign ACC_BUSY   = (state != ST_IDLE);
  assign ACC_DONE   = done;
  assign RD_DATA    = rd_data;
  assign BANK_ADDR  = bank_addr;
  assign BANK_WDATA = wdata;
  assign FLASH_ADDR = flash_addr;
  assign EE_ADDR    = ee_addr;

  // null region never strobes, so slot and hole writes vanish
  assign BANK_RD = (state == ST_ISSUE) && !wr &&
                   ((region == REG_BANK) || (region == REG_LINEAR)); // [R1]
  assign BANK_WR = (state == ST_ISSUE) && wr &&
                   ((region == REG_BANK) || (region == REG_LINEAR)); // [R1]
  // no write strobe exists toward flash or eeprom at all
  assign FLASH_RD = (state == ST_ISSUE) && !wr &&
                    (region == REG_FLASH); // [R11]
  assign EE_RD    = (state == ST_ISSUE) && !wr &&
                    (region == REG_EEPROM); // [R14]

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  property p_bank_write;
    take && ACC_WRITE && (decoded == REG_BANK)
      |=> BANK_WR && (BANK_WDATA == $past(WR_DATA));
  endproperty
  a_bank_write: assert property (p_bank_write) // [R1]
    else $error("banked write not issued with core data");

  property p_slot_read_zero;
    take && !ACC_WRITE && (ptr <= `BANK_TOP) && slot_hit
      |-> ##1 !BANK_RD && !BANK_WR ##2 ACC_DONE && (RD_DATA == 8'h00);
  endproperty
  a_slot_read_zero: assert property (p_slot_read_zero) // [R2]
    else $error("indirect slot access did not read zero");

  property p_bank_map;
    take && (decoded == REG_BANK) |=> ({4'h0, BANK_ADDR} == $past(ptr));
  endproperty
  a_bank_map: assert property (p_bank_map) // [R4]
    else $error("banked address differs from pointer");

  property p_linear_base;
    take && (ptr == `LIN_BASE) |=> (BANK_ADDR == 12'h020);
  endproperty
  a_linear_base: assert property (p_linear_base) // [R5]
    else $error("linear base does not hit first ram byte");

  property p_linear_step;
    take && (ptr == 16'h2050) |=> (BANK_ADDR == 12'h0a0);
  endproperty
  a_linear_step: assert property (p_linear_step) // [R7]
    else $error("linear window did not step into next bank");

  property p_linear_hole;
    take && !ACC_WRITE && lin_window && !lin_impl
      |-> ##1 !BANK_RD ##2 ACC_DONE && (RD_DATA == 8'h00);
  endproperty
  a_linear_hole: assert property (p_linear_hole) // [R6]
    else $error("unimplemented linear byte did not read zero");

  property p_flash_addr;
    take && ptr[`FLASH_SEL_BIT] |=> ({1'b1, FLASH_ADDR} == $past(ptr));
  endproperty
  a_flash_addr: assert property (p_flash_addr) // [R9]
    else $error("flash word address differs from pointer");

  property p_flash_low_byte;
    FLASH_RD |-> ##3 ACC_DONE && (RD_DATA == $past(FLASH_RDATA[7:0]));
  endproperty
  a_flash_low_byte: assert property (p_flash_low_byte) // [R10]
    else $error("flash read did not return the low byte");

  property p_flash_extra;
    take && ptr[`FLASH_SEL_BIT] |-> ##1 !ACC_DONE [*3] ##1 ACC_DONE;
  endproperty
  a_flash_extra: assert property (p_flash_extra) // [R12]
    else $error("flash access not four cycles to done");

  property p_nv_no_write;
    take && ACC_WRITE && ((decoded == REG_FLASH) ||
                          (decoded == REG_EEPROM))
      |-> ##1 (!FLASH_RD && !EE_RD && !BANK_WR) [*2];
  endproperty
  a_nv_no_write: assert property (p_nv_no_write) // [R11] [R14]
    else $error("nonvolatile view write produced a strobe");

  property p_ee_addr;
    take && !ACC_WRITE && (PTR_HIGH == `EE_HIGH)
      |=> EE_RD && (EE_ADDR == $past(PTR_LOW));
  endproperty
  a_ee_addr: assert property (p_ee_addr) // [R13]
    else $error("eeprom read not issued at the low byte");

  property p_ee_extra;
    EE_RD |-> ##1 !ACC_DONE ##1 !ACC_DONE ##1 ACC_DONE;
  endproperty
  a_ee_extra: assert property (p_ee_extra) // [R15]
    else $error("eeprom read not one cycle longer");

  property p_unmapped;
    take && (decoded == REG_NULL) |=> (!BANK_RD && !BANK_WR &&
                                       !FLASH_RD && !EE_RD) [*2];
  endproperty
  a_unmapped: assert property (p_unmapped) // [R16]
    else $error("unmapped pointer reached a memory");

  property p_c_flash_read;
    take && !ACC_WRITE && ptr[`FLASH_SEL_BIT] ##4 ACC_DONE;
  endproperty
  c_flash_read: cover property (p_c_flash_read);

  property p_c_ee_read;
    EE_RD ##3 ACC_DONE;
  endproperty
  c_ee_read: cover property (p_c_ee_read);

  property p_c_linear_write;
    take && ACC_WRITE && (decoded == REG_LINEAR) ##1 BANK_WR;
  endproperty
  c_linear_write: cover property (p_c_linear_write);

  property p_c_back_to_back;
    ACC_DONE && take;
  endproperty
  c_back_to_back: cover property (p_c_back_to_back);

endmodule // indirect_address_mapper
`default_nettype wire

/* File: rtl/linear_map.sv */
/*
  Linear ram window translation: pointer to absolute banked address.
  Assumes the caller checks the pointer lies in the linear window.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iam_params.svh"

module linear_map (
  input  wire logic [15:0] ptr,
  output logic      [11:0] abs_addr,
  output logic             in_window,
  output logic             implemented
);

  logic [15:0] offset;
  logic [11:0] bank_no;
  logic [11:0] index;

  assign in_window = (ptr >= `LIN_BASE) && (ptr <= `LIN_TOP);
  assign offset    = ptr - `LIN_BASE;
  // constant divide: small, and keeps the bank step exact at 80 bytes
  assign bank_no   = offset[11:0] / `RAM_BLOCK_BYTES; // [R5]
  assign index     = offset[11:0] % `RAM_BLOCK_BYTES; // [R7]
  // common ram sits above the 80-byte block, so it never appears
  assign abs_addr  = {bank_no[4:0],
                      7'(`RAM_BANK_BASE + index[6:0])}; // [R8]
  assign implemented = bank_no[4:0] < `RAM_BANKS_IMPL; // [R6]

endmodule // linear_map
`default_nettype wire

/* File: verif/mem_model.sv */
/*
  Memory model behind the mapper: banked ram, flash words, eeprom.
  Assumes single-cycle strobes; data is held until the next strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic        clk,
  input  wire logic [11:0] bank_addr,
  input  wire logic        bank_rd,
  input  wire logic        bank_wr,
  input  wire logic [7:0]  bank_wdata,
  output logic      [7:0]  bank_rdata,
  input  wire logic [14:0] flash_addr,
  input  wire logic        flash_rd,
  output logic      [13:0] flash_rdata,
  input  wire logic [7:0]  ee_addr,
  input  wire logic        ee_rd,
  output logic      [7:0]  ee_rdata
);
  logic [7:0] ram [4096];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      ram[i] = 8'(i) ^ 8'(i >> 8);
    end
    bank_rdata = 8'h00;
    flash_rdata = 14'h0000;
    ee_rdata = 8'h00;
  end
  // upper flash bits busy on purpose, so a wide read shows up
  always @(posedge clk) begin
    if (bank_wr) ram[bank_addr] <= bank_wdata;
    if (bank_rd) bank_rdata <= ram[bank_addr];
    if (flash_rd) flash_rdata <= {flash_addr[5:0],
                                  flash_addr[7:0] ^ flash_addr[14:7]};
    if (ee_rd) ee_rdata <= ~ee_addr ^ 8'h3c;
  end
endmodule // mem_model
`default_nettype wire

/* File: verif/testbench.sv */
/*
  Self-checking bench for the indirect address mapper.
  Assumes mem_model answers strobes the next cycle and holds its data.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        MCLK = 1'h0, RESET_N = 1'h0, ACC_REQ = 1'h0;
  logic        ACC_WRITE = 1'h0;
  logic [7:0]  PTR_HIGH = 8'h00, PTR_LOW = 8'h00, WR_DATA = 8'h00;
  logic        ACC_BUSY, ACC_DONE, BANK_RD, BANK_WR, FLASH_RD, EE_RD;
  logic [7:0]  RD_DATA, BANK_WDATA, BANK_RDATA, EE_ADDR, EE_RDATA;
  logic [11:0] BANK_ADDR;
  logic [14:0] FLASH_ADDR, cap;
  logic [13:0] FLASH_RDATA;
  logic [15:0] sig;
  logic [7:0]  sh [4096];
  logic [7:0]  last_rd = 8'h00;
  int          n_errors = 0, tests_run = 0, seed = 20;
  logic [15:0] corner [22] = '{16'h0000, 16'h0001, 16'h0081, 16'h0002,
    16'h007f, 16'h0fff, 16'h1000, 16'h1fff, 16'h2000, 16'h204f, 16'h2050,
    16'h240f, 16'h2410, 16'h29af, 16'h29b0, 16'h6fff, 16'h7000, 16'h70ff,
    16'h7100, 16'h7fff, 16'h8000, 16'hffff};

  indirect_address_mapper indirect_address_mapper_i (.MCLK(MCLK),
    .RESET_N(RESET_N), .ACC_REQ(ACC_REQ), .ACC_WRITE(ACC_WRITE),
    .PTR_HIGH(PTR_HIGH), .PTR_LOW(PTR_LOW), .WR_DATA(WR_DATA),
    .ACC_BUSY(ACC_BUSY), .ACC_DONE(ACC_DONE), .RD_DATA(RD_DATA),
    .BANK_ADDR(BANK_ADDR), .BANK_RD(BANK_RD), .BANK_WR(BANK_WR),
    .BANK_WDATA(BANK_WDATA), .BANK_RDATA(BANK_RDATA),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_RD(FLASH_RD),
    .FLASH_RDATA(FLASH_RDATA), .EE_ADDR(EE_ADDR), .EE_RD(EE_RD),
    .EE_RDATA(EE_RDATA));
  mem_model mem_model_i (.clk(MCLK), .bank_addr(BANK_ADDR),
    .bank_rd(BANK_RD), .bank_wr(BANK_WR), .bank_wdata(BANK_WDATA),
    .bank_rdata(BANK_RDATA), .flash_addr(FLASH_ADDR), .flash_rd(FLASH_RD),
    .flash_rdata(FLASH_RDATA), .ee_addr(EE_ADDR), .ee_rd(EE_RD),
    .ee_rdata(EE_RDATA));

  always #4 MCLK = ~MCLK;

  // strobe counts per access, and the address seen with the strobe
  always @(posedge MCLK) begin
    if (BANK_RD | BANK_WR) cap <= 15'(BANK_ADDR);
    if (FLASH_RD) cap <= FLASH_ADDR;
    if (EE_RD) cap <= 15'(EE_ADDR);
    sig <= sig + {3'h0, BANK_RD, 3'h0, BANK_WR, 3'h0, FLASH_RD, 3'h0, EE_RD};
  end

  task automatic conclude;
    $display("errors %0d compares %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask

  // {kind, target}: kind 0 none, 1 banked ram, 2 flash, 3 eeprom
  function automatic logic [16:0] ref_map(input logic [15:0] p);
    logic [15:0] off;
    logic [15:0] bk;
    off = p - 16'h2000;
    bk = off / 16'd80;
    if (p[15]) return {2'h2, p[14:0]};
    if (p[15:8] == 8'h70) return {2'h3, 7'h00, p[7:0]};
    if (p < 16'h1000)
      return (p[6:0] < 7'h02) ? 17'h0 : {2'h1, 3'h0, p[11:0]};
    if (p >= 16'h2000 && p <= 16'h29af && bk < 16'd13)
      return {2'h1, 3'h0, bk[4:0], 7'(16'h20 + off % 16'd80)};
    return 17'h0;
  endfunction

  task automatic acc(input logic we, input logic [15:0] p,
                     input logic [7:0] wd);
    logic [16:0] m;
    logic [15:0] es;
    int          n;
    m = ref_map(p);
    case (m[16:15])
      2'h1: es = we ? 16'h0100 : 16'h1000;
      2'h2: es = we ? 16'h0000 : 16'h0010;
      2'h3: es = we ? 16'h0000 : 16'h0001;
      default: es = 16'h0000;
    endcase
    if (!we) begin
      case (m[16:15])
        2'h1: last_rd = sh[m[11:0]];
        2'h2: last_rd = p[7:0] ^ p[14:7];
        2'h3: last_rd = ~p[7:0] ^ 8'h3c;
        default: last_rd = 8'h00;
      endcase
    end
    else if (m[16:15] == 2'h1) sh[m[11:0]] = wd;
    sig = 16'h0000;
    ACC_REQ = 1'h1;
    ACC_WRITE = we;
    {PTR_HIGH, PTR_LOW} = p;
    WR_DATA = wd;
    @(posedge MCLK);
    #1;
    // dropped after the taking edge; a held request would be taken again
    ACC_REQ = 1'h0;
    chk8({7'h00, ACC_BUSY}, 8'h01);
    n = 0;
    while (ACC_DONE !== 1'h1 && n < 8) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    if (n == 8) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, 8'h00, 8'h01);
      conclude();
    end
    chk16(16'(n), (m[16:15] == 2'h2 || (m[16:15] == 2'h3 && !we)) ?
          16'h0003 : 16'h0002);
    chk16(sig, es);
    if (es != 16'h0000)
      chk16({1'h0, cap}, {1'h0, m[14:0]});
    chk8(RD_DATA, last_rd);
  endtask

  initial begin
    logic [31:0] r;
    logic [15:0] p;
    for (int i = 0; i < 4096; i++) begin
      sh[i] = 8'(i) ^ 8'(i >> 8);
    end
    repeat (4) @(posedge MCLK);
    #1;
    RESET_N = 1'h1;
    foreach (corner[i]) begin
      acc(1'h1, corner[i], 8'ha5 ^ 8'(i));
      acc(1'h0, corner[i], 8'h00);
    end
    acc(1'h1, 16'h204f, 8'h11);
    acc(1'h0, 16'h006f, 8'h00);
    acc(1'h1, 16'h00a0, 8'h22);
    acc(1'h0, 16'h2050, 8'h00);
    ACC_REQ = 1'h1;
    @(posedge MCLK);
    #1;
    RESET_N = 1'h0;
    ACC_REQ = 1'h0;
    #1;
    chk16({ACC_BUSY, ACC_DONE, BANK_RD, BANK_WR, FLASH_RD, EE_RD,
           RD_DATA}, 16'h0000);
    repeat (4) @(posedge MCLK);
    #1;
    RESET_N = 1'h1;
    last_rd = 8'h00;
    for (int k = 0; k < 400; k++) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: p = {4'h0, r[13:2]};
        2'h1: p = 16'h2000 + {4'h0, r[13:2]};
        2'h2: p = {1'h1, r[16:2]};
        default: p = {7'h38, r[2], r[10:3]};
      endcase
      acc(r[20], p, r[28:21]);
    end
    conclude();
  end
endmodule // testbench
`default_nettype wire
